/* logic/udu_regs.vh */
// register offsets, field positions, reset values and timing counts of the serial channel
`ifndef UDU_REGS_VH
`define UDU_REGS_VH

// register offsets; the line-control divisor-access bit selects the overlays at 0 and 1
`define UDU_OFF_DATA        3'h0
`define UDU_OFF_IER         3'h1
`define UDU_OFF_ISR         3'h2
`define UDU_OFF_LCR         3'h3
`define UDU_OFF_MCR         3'h4
`define UDU_OFF_LSR         3'h5
`define UDU_OFF_MSR         3'h6
`define UDU_OFF_SPR         3'h7

// reset values
`define UDU_RST_IER         8'h00
`define UDU_RST_LCR         8'h00
`define UDU_RST_MCR         8'h00
`define UDU_RST_FCR         8'h00
`define UDU_RST_DIV         16'h0001
`define UDU_RST_SPR         8'h00

// field positions
`define UDU_LCR_DIV_ACCESS  7
`define UDU_LCR_BREAK       6
`define UDU_LCR_PAR_EN      3
`define UDU_LCR_STOP        2
`define UDU_IER_RECEIVER_READY       0
`define UDU_IER_TRANSMIT_EMPTY        1
`define UDU_IER_RXSTAT      2
`define UDU_IER_MODEM       3
`define UDU_IER_SLEEP       4
`define UDU_FCR_FIFO_EN     0
`define UDU_FCR_FLUSH_RX    1
`define UDU_FCR_FLUSH_TX    2
`define UDU_MCR_DTR         0
`define UDU_MCR_RTS         1
`define UDU_MCR_LOOP        4
`define UDU_MCR_FLOW        5

// interrupt status codes, low six bits
`define UDU_ISR_NONE        6'h01
`define UDU_ISR_RXSTAT      6'h06
`define UDU_ISR_RXDATA      6'h04
`define UDU_ISR_TIMEOUT     6'h0C
`define UDU_ISR_TRANSMIT_EMPTY        6'h02
`define UDU_ISR_MODEM       6'h00

// receive queue and timing
`define UDU_FIFO_DEPTH      5'd16
`define UDU_OVERSAMPLE      6'd16
`define UDU_CLK_HZ          200000000
`define UDU_MAX_BPS         920000
`define UDU_MIN_DIVISOR     (`UDU_CLK_HZ / (16 * `UDU_MAX_BPS))

`endif

/* logic/udu_mem.v */
// small register-output memory holding the receive queue entries
`timescale 1ns/1ps
`default_nettype none

module udu_mem #(
  parameter W  = 11,
  parameter AW = 4
) (
  input  wire          i_mclk,
  input  wire          i_resetn,
  input  wire          i_wr,
  input  wire [AW-1:0] i_waddr,
  input  wire [W-1:0]  i_wdata,
  input  wire [AW-1:0] i_raddr,
  output reg  [W-1:0]  o_rdata_q
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  // storage has no reset; only the output register is cleared
  always @(posedge i_mclk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read data follows the read address one cycle later
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata_q <= {W{1'b0}};
    end else begin
      o_rdata_q <= mem[i_raddr];
    end
  end
endmodule

`default_nettype wire

/* logic/udu_channel.v */
// one serial channel: register map, transmitter, receiver with queue, modem lines
//
// Contract
// - characters of 5, 6, 7 or 8 data bits
// - even, odd, mark, space or no parity
// - one, one and half, two stop bits
// - bit rate reaches 920 kbit/s per channel
// - system reset sets every register to known state (the receive queue storage is not reset)
// - request and ready outputs high after reset, loopback
// - all modem handshake pins are active low
// - terminal-ready output never affects the transfers
// - ten byte registers, line-control selects the overlay
// - enable bit 0 gates receiver-ready interrupt
// - enable bit 1 gates transmitter-empty interrupt
// - enable bit 2 gates receiver status interrupt
// - enable bit 3 gates modem change interrupt
// - enable bit 4 stops the channel clock
// - core clock multiplied up from crystal reference (the channel has no multiplier; i_mclk stands for that clock)
// - bypass pin low uses external clock directly (the channel only reports it on o_pll_bypassed)
// - host reaches registers through vendor control requests
// - offset 2 is queue control write, status read
// - status shows highest pending of five sources
`timescale 1ns/1ps
`default_nettype none
`include "udu_regs.vh"

module udu_channel (
  input  wire       i_mclk,
  input  wire       i_resetn,
  input  wire [2:0] i_reg_addr,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  input  wire [7:0] i_reg_wdata,
  output reg  [7:0] o_reg_rdata,
  input  wire       i_rx,
  output reg        o_tx,
  input  wire       i_carrier_detect_in_n,
  input  wire       i_set_ready_in_n,
  input  wire       i_clear_to_send_in_n,
  input  wire       i_ring_detect_in_n,
  output reg        o_request_to_send_out_n,
  output reg        o_terminal_ready_out_n,
  input  wire       i_pll_bypass_test_n,
  output reg        o_pll_bypassed,
  output reg        o_irq_pending,
  output wire       o_sleeping
);
  localparam S_IDLE  = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA  = 3'd2;
  localparam S_PAR   = 3'd3;
  localparam S_STOP  = 3'd4;

  // control registers
  reg [7:0]  ier_q, lcr_q, mcr_q, fcr_q, spr_q;
  reg [15:0] div_q;
  wire dlab      = lcr_q[`UDU_LCR_DIV_ACCESS];
  wire fifo_mode = fcr_q[`UDU_FCR_FIFO_EN];
  wire loop      = mcr_q[`UDU_MCR_LOOP];
  wire wr_hit    = i_reg_wr;
  wire rd_hit    = i_reg_rd;

  // parity bit for a character: force, odd or even over the valid data bits
  function par_of;
    input [7:0] d;
    input [7:0] line_control_reg;
    reg   [7:0] m;
    begin
      m = d & (8'hFF >> (2'd3 - line_control_reg[1:0]));
      if (line_control_reg[5]) par_of = ~line_control_reg[4];
      else        par_of = line_control_reg[4] ? ^m : ~^m;
    end
  endfunction

  // two-flop synchronisers for every pin input: rx, cts, dsr, ri, cd, bypass
  reg [5:0] sync1_q, sync2_q;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
    end else begin
      sync1_q <= {i_pll_bypass_test_n, i_carrier_detect_in_n, i_ring_detect_in_n,
                  i_set_ready_in_n, i_clear_to_send_in_n, i_rx};
      sync2_q <= sync1_q;
    end
  end

  // asserted modem inputs, active low pins; loopback feeds the control bits back
  wire cts_a = loop ? mcr_q[1] : ~sync2_q[1];
  wire dsr_a = loop ? mcr_q[0] : ~sync2_q[2];
  wire ri_a  = loop ? mcr_q[2] : ~sync2_q[3];
  wire cd_a  = loop ? mcr_q[3] : ~sync2_q[4];

  // 16x baud tick; sleep freezes the divider, which stops the transmitter, the receiver and the receive timeout
  reg  [15:0] baud_cnt_q;
  wire        sleep = ier_q[`UDU_IER_SLEEP];
  wire [15:0] div_m1 = (div_q == 16'h0000) ? 16'h0000 : div_q - 16'h0001;
  wire        tick = ~sleep & (baud_cnt_q == 16'h0000);
  assign o_sleeping = sleep;
  // the 16-bit divisor reaches the top rate with a small divisor at this clock
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) baud_cnt_q <= 16'h0000;
    else if (!sleep) baud_cnt_q <= tick ? div_m1 : baud_cnt_q - 16'h0001;
  end

  // i_mclk stands for the multiplied core clock; the bypass strap is only reported
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) o_pll_bypassed <= 1'b0;
    else o_pll_bypassed <= ~sync2_q[5];
  end

  // transmitter
  reg [2:0] tx_st_q, tx_bit_q;
  reg [5:0] tx_sub_q;
  reg [7:0] tx_sh_q, thr_q;
  reg       tx_line_q, tx_par_q, thr_full_q;
  wire [2:0] last_bit = 3'd4 + {1'b0, lcr_q[1:0]};
  wire [5:0] stop_len = !lcr_q[`UDU_LCR_STOP] ? 6'd16 :
                        (lcr_q[1:0] == 2'b00) ? 6'd24 : 6'd32;
  wire flow_en  = mcr_q[`UDU_MCR_FLOW];
  wire tx_take  = tick & (tx_st_q == S_IDLE) & thr_full_q & (~flow_en | cts_a);
  wire tx_idle  = (tx_st_q == S_IDLE) & ~thr_full_q;

  // serializer; terminal-ready plays no part here
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_st_q   <= S_IDLE;
      tx_sub_q  <= 6'd0;
      tx_bit_q  <= 3'd0;
      tx_sh_q   <= 8'h00;
      tx_par_q  <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (tick) begin
      tx_sub_q <= tx_sub_q + 6'd1;
      case (tx_st_q)
        S_IDLE: begin
          tx_sub_q <= 6'd0;
          if (tx_take) begin
            tx_st_q   <= S_START;
            tx_sh_q   <= thr_q;
            tx_par_q  <= par_of(thr_q, lcr_q);
            tx_line_q <= 1'b0;
          end
        end
        S_START: if (tx_sub_q == 6'd15) begin
          tx_sub_q  <= 6'd0;
          tx_bit_q  <= 3'd0;
          tx_st_q   <= S_DATA;
          tx_line_q <= tx_sh_q[0];
        end
        S_DATA: if (tx_sub_q == 6'd15) begin
          tx_sub_q <= 6'd0;
          tx_sh_q  <= tx_sh_q >> 1;
          tx_bit_q <= tx_bit_q + 3'd1;
          if (tx_bit_q == last_bit) begin
            tx_st_q   <= lcr_q[`UDU_LCR_PAR_EN] ? S_PAR : S_STOP;
            tx_line_q <= lcr_q[`UDU_LCR_PAR_EN] ? tx_par_q : 1'b1;
          end else begin
            tx_line_q <= tx_sh_q[1];
          end
        end
        S_PAR: if (tx_sub_q == 6'd15) begin
          tx_sub_q  <= 6'd0;
          tx_st_q   <= S_STOP;
          tx_line_q <= 1'b1;
        end
        S_STOP: if (tx_sub_q == stop_len - 6'd1) begin
          tx_st_q <= S_IDLE;
        end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end

  // break forces the line low; loopback keeps the pin idle
  wire tx_wire = tx_line_q & ~lcr_q[`UDU_LCR_BREAK];
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) o_tx <= 1'b1;
    else o_tx <= loop ? 1'b1 : tx_wire;
  end

  // receiver
  reg [2:0] rx_st_q, rx_bit_q;
  reg [3:0] rx_sub_q;
  reg [7:0] rx_sh_q;
  reg       rx_perr_q, rx_any1_q, rx_push_q;
  reg [10:0] rx_word_q;
  wire rx_in = loop ? tx_wire : sync2_q[0];

  // samples each bit at its centre, 16x oversampled
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_st_q   <= S_IDLE;
      rx_sub_q  <= 4'd0;
      rx_bit_q  <= 3'd0;
      rx_sh_q   <= 8'h00;
      rx_perr_q <= 1'b0;
      rx_any1_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word_q <= 11'h000;
    end else begin
      rx_push_q <= 1'b0;
      if (tick) begin
        rx_sub_q <= rx_sub_q + 4'd1;
        case (rx_st_q)
          S_IDLE: begin
            rx_sub_q <= 4'd0;
            if (!rx_in) rx_st_q <= S_START;
          end
          S_START: if (rx_sub_q == 4'd7) begin
            rx_sub_q  <= 4'd0;
            rx_bit_q  <= 3'd0;
            rx_sh_q   <= 8'h00;
            rx_any1_q <= 1'b0;
            rx_perr_q <= 1'b0;
            rx_st_q   <= rx_in ? S_IDLE : S_DATA; // glitch rejected
          end
          S_DATA: if (rx_sub_q == 4'd15) begin
            rx_sh_q[rx_bit_q] <= rx_in;
            rx_any1_q <= rx_any1_q | rx_in;
            rx_bit_q  <= rx_bit_q + 3'd1;
            if (rx_bit_q == last_bit) rx_st_q <= lcr_q[`UDU_LCR_PAR_EN] ? S_PAR : S_STOP;
          end
          S_PAR: if (rx_sub_q == 4'd15) begin
            rx_perr_q <= rx_in ^ par_of(rx_sh_q, lcr_q);
            rx_any1_q <= rx_any1_q | rx_in;
            rx_st_q   <= S_STOP;
          end
          S_STOP: if (rx_sub_q == 4'd15) begin
            // only the first stop bit is checked, so short gaps are accepted
            rx_push_q <= 1'b1;
            rx_word_q <= {~rx_any1_q & ~rx_in, ~rx_in, rx_perr_q, rx_sh_q};
            rx_st_q   <= S_IDLE;
          end
          default: rx_st_q <= S_IDLE;
        endcase
      end
    end
  end

  // receive queue: sixteen entries in queue mode, one in byte mode
  reg  [3:0]  rd_ptr_q, wr_ptr_q;
  reg  [4:0]  rx_cnt_q;
  wire [10:0] head;
  wire [4:0]  depth   = fifo_mode ? `UDU_FIFO_DEPTH : 5'd1;
  wire        rx_full = (rx_cnt_q >= depth);
  wire        push    = rx_push_q & ~rx_full;
  wire        rd_data = rd_hit & (i_reg_addr == `UDU_OFF_DATA) & ~dlab;
  wire        pop     = rd_data & (rx_cnt_q != 5'd0);
  wire        fcr_wr  = wr_hit & (i_reg_addr == `UDU_OFF_ISR);
  wire        rx_flush = fcr_wr & (i_reg_wdata[`UDU_FCR_FLUSH_RX] |
                         (i_reg_wdata[`UDU_FCR_FIFO_EN] != fifo_mode));

  udu_mem #(.W(11), .AW(4)) u_rxq (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_wr      (push),
    .i_waddr   (wr_ptr_q),
    .i_wdata   (rx_word_q),
    .i_raddr   (rd_ptr_q),
    .o_rdata_q (head)
  );

  // queue pointers; a flush empties it at once
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_ptr_q <= 4'd0;
      wr_ptr_q <= 4'd0;
      rx_cnt_q <= 5'd0;
    end else if (rx_flush) begin
      rd_ptr_q <= 4'd0;
      wr_ptr_q <= 4'd0;
      rx_cnt_q <= 5'd0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 4'd1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 4'd1;
      rx_cnt_q <= rx_cnt_q + {4'd0, push} - {4'd0, pop};
    end
  end

  // trigger level; byte mode always uses one
  reg [4:0] trig;
  always @* begin
    case (fcr_q[7:6])
      2'b00:   trig = 5'd1;
      2'b01:   trig = 5'd4;
      2'b10:   trig = 5'd8;
      default: trig = 5'd14;
    endcase
    if (!fifo_mode) trig = 5'd1;
  end

  // receive timeout: four character times of silence with data waiting
  reg  [9:0] to_cnt_q;
  wire [3:0] char_bits = 4'd7 + {2'd0, lcr_q[1:0]} + {3'd0, lcr_q[`UDU_LCR_PAR_EN]};
  wire       timeout   = (to_cnt_q >= {char_bits, 6'd0});
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) to_cnt_q <= 10'd0;
    else if (push | pop | rx_flush | ~fifo_mode | (rx_cnt_q == 5'd0)) to_cnt_q <= 10'd0;
    else if (tick & ~timeout) to_cnt_q <= to_cnt_q + 10'd1;
  end

  // line status error flags; a new error wins over the clearing read
  reg  ovr_q, pe_q, fe_q, brk_q;
  wire rd_lsr = rd_hit & (i_reg_addr == `UDU_OFF_LSR);
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovr_q <= 1'b0;
      pe_q  <= 1'b0;
      fe_q  <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      ovr_q <= (rx_push_q & rx_full) | (ovr_q & ~rd_lsr);
      pe_q  <= (push & rx_word_q[8])  | (pe_q  & ~rd_lsr);
      fe_q  <= (push & rx_word_q[9])  | (fe_q  & ~rd_lsr);
      brk_q <= (push & rx_word_q[10]) | (brk_q & ~rd_lsr);
    end
  end
  wire [7:0] line_status_reg = {fifo_mode & (pe_q | fe_q | brk_q), tx_idle, ~thr_full_q,
                    brk_q, fe_q, pe_q, ovr_q, rx_cnt_q != 5'd0};

  // modem status: deltas latch until the status read, set wins
  reg  [3:0] mdm_prev_q, mdm_dlt_q;
  wire [3:0] mdm_now = {cd_a, ri_a, dsr_a, cts_a};
  wire [3:0] mdm_chg = {mdm_now[3] ^ mdm_prev_q[3], ~mdm_now[2] & mdm_prev_q[2],
                        mdm_now[1:0] ^ mdm_prev_q[1:0]};
  wire       rd_msr  = rd_hit & (i_reg_addr == `UDU_OFF_MSR);
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mdm_prev_q <= 4'h0;
      mdm_dlt_q  <= 4'h0;
    end else begin
      mdm_prev_q <= mdm_now;
      mdm_dlt_q  <= mdm_chg | (mdm_dlt_q & {4{~rd_msr}});
    end
  end

  // interrupt status, highest priority first
  reg  [5:0] isr_lo;
  reg        transmit_empty_int_q;
  wire rx_stat_int = ier_q[`UDU_IER_RXSTAT] & (ovr_q | pe_q | fe_q | brk_q);
  wire rx_data_int = ier_q[`UDU_IER_RECEIVER_READY] & (rx_cnt_q >= trig);
  wire to_int      = ier_q[`UDU_IER_RECEIVER_READY] & timeout;
  wire transmit_empty_int    = ier_q[`UDU_IER_TRANSMIT_EMPTY] & transmit_empty_int_q;
  wire modem_int   = ier_q[`UDU_IER_MODEM] & (|mdm_dlt_q);
  always @* begin
    if (rx_stat_int)      isr_lo = `UDU_ISR_RXSTAT;
    else if (rx_data_int) isr_lo = `UDU_ISR_RXDATA;
    else if (to_int)      isr_lo = `UDU_ISR_TIMEOUT;
    else if (transmit_empty_int)    isr_lo = `UDU_ISR_TRANSMIT_EMPTY;
    else if (modem_int)   isr_lo = `UDU_ISR_MODEM;
    else                  isr_lo = `UDU_ISR_NONE;
  end
  wire [7:0] interrupt_status_reg = {fifo_mode, fifo_mode, isr_lo};

  // holding register and its empty interrupt
  wire thr_wr  = wr_hit & (i_reg_addr == `UDU_OFF_DATA) & ~dlab;
  wire rd_isr3 = rd_hit & (i_reg_addr == `UDU_OFF_ISR) & (isr_lo == `UDU_ISR_TRANSMIT_EMPTY);
  wire tx_flush = fcr_wr & i_reg_wdata[`UDU_FCR_FLUSH_TX];
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
      transmit_empty_int_q <= 1'b0;
    end else begin
      if (thr_wr) thr_q <= i_reg_wdata;
      thr_full_q <= thr_wr | (thr_full_q & ~tx_take & ~tx_flush);
      // emptying sets it, a write or the level-3 status read clears it
      transmit_empty_int_q <= ((tx_take | tx_flush) & thr_full_q) | (transmit_empty_int_q & ~thr_wr & ~rd_isr3);
    end
  end

  // register writes; the divisor-access bit picks the overlay at 0 and 1
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ier_q <= `UDU_RST_IER;
      lcr_q <= `UDU_RST_LCR;
      mcr_q <= `UDU_RST_MCR;
      fcr_q <= `UDU_RST_FCR;
      div_q <= `UDU_RST_DIV;
      spr_q <= `UDU_RST_SPR;
    end else if (wr_hit) begin
      case (i_reg_addr)
        `UDU_OFF_DATA: if (dlab) div_q[7:0] <= i_reg_wdata;
        `UDU_OFF_IER:  if (dlab) div_q[15:8] <= i_reg_wdata; else ier_q <= {3'b000, i_reg_wdata[4:0]};
        `UDU_OFF_ISR:  fcr_q <= {i_reg_wdata[7:6], 5'b00000, i_reg_wdata[0]}; // flush bits self-clear
        `UDU_OFF_LCR:  lcr_q <= i_reg_wdata;
        `UDU_OFF_MCR:  mcr_q <= {2'b00, i_reg_wdata[5:0]};
        `UDU_OFF_SPR:  spr_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // read data register, captured on the read strobe; the host's vendor requests end here
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) o_reg_rdata <= 8'h00;
    else if (rd_hit) begin
      case (i_reg_addr)
        `UDU_OFF_DATA: o_reg_rdata <= dlab ? div_q[7:0] : head[7:0];
        `UDU_OFF_IER:  o_reg_rdata <= dlab ? div_q[15:8] : ier_q;
        `UDU_OFF_ISR:  o_reg_rdata <= interrupt_status_reg;
        `UDU_OFF_LCR:  o_reg_rdata <= lcr_q;
        `UDU_OFF_MCR:  o_reg_rdata <= mcr_q;
        `UDU_OFF_LSR:  o_reg_rdata <= line_status_reg;
        `UDU_OFF_MSR:  o_reg_rdata <= {mdm_now, mdm_dlt_q};
        default:       o_reg_rdata <= spr_q;
      endcase
    end
  end

  // modem outputs: active low, held inactive in loopback; auto flow drops request at trigger
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_request_to_send_out_n <= 1'b1;
      o_terminal_ready_out_n  <= 1'b1;
      o_irq_pending           <= 1'b0;
    end else begin
      o_request_to_send_out_n <= loop | ~mcr_q[`UDU_MCR_RTS] | (flow_en & (rx_cnt_q >= trig));
      o_terminal_ready_out_n  <= loop | ~mcr_q[`UDU_MCR_DTR];
      o_irq_pending           <= ~isr_lo[0];
    end
  end
endmodule

`default_nettype wire

/* verification/udu_channel_chk.sv */
// checker of register readback and handshake pins
`timescale 1ns/1ps
`default_nettype none
`include "udu_regs.vh"
module udu_chk (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic [2:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_pll_bypass_test_n,
  input wire logic       o_request_to_send_out_n,
  input wire logic       o_terminal_ready_out_n,
  input wire logic       o_pll_bypassed,
  input wire logic       o_irq_pending,
  input wire logic       o_sleeping
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic [7:0]  lcr_q, mcr_q, ier_q, spr_q;
  logic [15:0] div_q;
  wire         dl = lcr_q[`UDU_LCR_DIV_ACCESS];
  // shadow of writable registers, reserved bits zero
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lcr_q <= `UDU_RST_LCR;
      mcr_q <= `UDU_RST_MCR;
      ier_q <= `UDU_RST_IER;
      spr_q <= `UDU_RST_SPR;
      div_q <= `UDU_RST_DIV;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `UDU_OFF_DATA: if (dl) div_q[7:0] <= i_reg_wdata;
        `UDU_OFF_IER: if (dl) div_q[15:8] <= i_reg_wdata; else ier_q <= {3'h0, i_reg_wdata[4:0]};
        `UDU_OFF_LCR: lcr_q <= i_reg_wdata;
        `UDU_OFF_MCR: mcr_q <= {2'h0, i_reg_wdata[5:0]};
        `UDU_OFF_SPR: spr_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end
  a_reset_idle_lines: assert property ($rose(i_resetn) |-> o_request_to_send_out_n && o_terminal_ready_out_n)
    else $error("lines active after reset");
  a_reset_quiet_flags: assert property ($rose(i_resetn) |-> !o_irq_pending && !o_pll_bypassed)
    else $error("flags set after reset");
  a_loop_lines_high: assert property (mcr_q[`UDU_MCR_LOOP] |=> o_request_to_send_out_n && o_terminal_ready_out_n)
    else $error("lines active in loopback");
  // outputs lag the control register by one cycle
  a_modem_polarity: assert property (!mcr_q[`UDU_MCR_LOOP] && $stable(mcr_q) |=>
    o_request_to_send_out_n != $past(mcr_q[`UDU_MCR_RTS]) && o_terminal_ready_out_n != $past(mcr_q[`UDU_MCR_DTR]))
    else $error("lines differ from control");
  a_sleep_from_ier: assert property (i_reg_wr && i_reg_addr == `UDU_OFF_IER && !dl |=>
    o_sleeping == $past(i_reg_wdata[`UDU_IER_SLEEP])) else $error("sleep wrong");
  a_bypass_on: assert property (!i_pll_bypass_test_n [*5] |-> o_pll_bypassed)
    else $error("bypass missed");
  a_bypass_off: assert property (i_pll_bypass_test_n [*5] |-> !o_pll_bypassed)
    else $error("bypass while strap high");
  a_scratch_read: assert property (i_reg_rd && i_reg_addr == `UDU_OFF_SPR |=> o_reg_rdata == spr_q)
    else $error("scratch read wrong");
  a_divisor_read: assert property (i_reg_rd && dl && i_reg_addr[2:1] == 2'h0 |=>
    o_reg_rdata == ($past(i_reg_addr[0]) ? div_q[15:8] : div_q[7:0])) else $error("divisor read wrong");
  a_ier_read: assert property (i_reg_rd && !dl && i_reg_addr == `UDU_OFF_IER |=> o_reg_rdata == ier_q)
    else $error("enable read wrong");
  a_lcr_read: assert property (i_reg_rd && i_reg_addr == `UDU_OFF_LCR |=> o_reg_rdata == lcr_q)
    else $error("control read wrong");
  c_div_read: cover property (i_reg_rd && dl);
  c_loopback: cover property (mcr_q[`UDU_MCR_LOOP]);
  c_irq: cover property (o_irq_pending);
endmodule
`default_nettype wire

/* verification/udu_modem.sv */
// far-side modem: frame sender, line sampler, handshake lines
`timescale 1ns/1ps
`default_nettype none
module udu_modem #(
  parameter int BIT_CYC = 16
) (
  input  wire logic i_mclk,
  input  wire logic i_tx,
  output var  logic o_rx,
  output var  logic o_cd_n,
  output var  logic o_ri_n,
  output var  logic o_dsr_n,
  output var  logic o_cts_n
);
  // idle mark, handshake lines inactive high
  initial begin
    o_rx = 1'b1;
    {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} = 4'hF;
  end
  // bit 0 first, called just after a clock edge
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_rx = bits[i];
      repeat (BIT_CYC) @(posedge i_mclk);
      #1;
    end
    o_rx = 1'b1;
  endtask
  // samples mid half-bit, tolerating start jitter
  task automatic sample(input int n, output logic [47:0] v);
    v = 48'h0;
    @(negedge i_tx);
    repeat (BIT_CYC / 4) @(posedge i_mclk);
    for (int i = 0; i < n; i++) begin
      v[i] = i_tx;
      repeat (BIT_CYC / 2) @(posedge i_mclk);
    end
  endtask
  // cd, ri, dsr, cts; low is asserted
  task automatic set_lines(input logic [3:0] l);
    {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} = l;
  endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of one channel and a modem model
`timescale 1ns/1ps
`default_nettype none
`include "udu_regs.vh"
module tb;
  logic        i_mclk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [2:0]  i_reg_addr = 3'h0;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_pll_bypass_test_n = 1'b1;
  wire  [7:0]  o_reg_rdata;
  wire         i_rx, o_tx, cd_n, ri_n, dsr_n, cts_n;
  wire         o_request_to_send_out_n, o_terminal_ready_out_n, o_pll_bypassed, o_irq_pending, o_sleeping;
  int          mismatches = 0;
  int          n_checks = 0;
  int          np;
  logic [7:0]  v;
  logic [47:0] ev, got;
  logic [7:0]  fmt [6] = '{8'h03, 8'h1A, 8'h0D, 8'h2C, 8'h3B, 8'h0F};
  always #2.5 i_mclk = ~i_mclk;
  udu_channel udu_channel_i (.*, .i_carrier_detect_in_n(cd_n), .i_set_ready_in_n(dsr_n),
    .i_clear_to_send_in_n(cts_n), .i_ring_detect_in_n(ri_n));
  udu_modem udu_modem_i (.i_mclk, .i_tx(o_tx), .o_rx(i_rx), .o_cd_n(cd_n), .o_ri_n(ri_n), .o_dsr_n(dsr_n),
    .o_cts_n(cts_n));
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // one-cycle strobes, 1 ns after the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    tick(1);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick(1);
    i_reg_wr = 1'b0;
  endtask
  // registered data is taken after the strobe edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    tick(1);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    tick(1);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, seen);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string nm);
    rd(a, v);
    chk(nm, exp, v);
  endtask
  task automatic push(input logic b, input int k);
    repeat (k) ev[np++] = b;
  endtask
  // expected half bits: start, data lsb first, parity, stop
  task automatic frame(input logic [7:0] d, input logic [7:0] l);
    int nd;
    nd = 5 + l[1:0];
    push(1'b0, 2);
    for (int i = 0; i < nd; i++) push(d[i], 2);
    if (l[3]) push(l[5] ? ~l[4] : ^(d & (8'hFF >> (8 - nd))) ^ ~l[4], 2);
    push(1'b1, !l[2] ? 2 : (nd == 5 ? 3 : 4));
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog: tests need about 15 us
  initial begin
    #300000;
    mismatches++;
    final_report;
  end
  initial begin
    tick(5);
    i_resetn = 1'b1;
    rc(`UDU_OFF_IER, 8'h00, "ier");
    rc(`UDU_OFF_LCR, 8'h00, "lcr");
    rc(`UDU_OFF_MCR, 8'h00, "mcr");
    rc(`UDU_OFF_ISR, 8'h01, "isr");
    chk("idle lines", 2'h3, {o_request_to_send_out_n, o_terminal_ready_out_n});
    rd(`UDU_OFF_LSR, v);
    chk("lsr", 8'h60, v & 8'h61);
    wr(`UDU_OFF_LSR, 8'h1E);
    rd(`UDU_OFF_LSR, v);
    chk("lsr ro", 8'h60, v & 8'h61);
    wr(`UDU_OFF_SPR, 8'hA5);
    rc(`UDU_OFF_SPR, 8'hA5, "spr");
    wr(`UDU_OFF_IER, 8'hE7);
    rc(`UDU_OFF_IER, 8'h07, "ier rsv");
    wr(`UDU_OFF_LCR, 8'h80);
    rc(`UDU_OFF_DATA, 8'h01, "div lo");
    rc(`UDU_OFF_IER, 8'h00, "div hi");
    wr(`UDU_OFF_DATA, 8'h34);
    wr(`UDU_OFF_IER, 8'h12);
    rc(`UDU_OFF_DATA, 8'h34, "div lo");
    rc(`UDU_OFF_IER, 8'h12, "div hi");
    wr(`UDU_OFF_DATA, 8'h01);
    wr(`UDU_OFF_IER, 8'h00);
    wr(`UDU_OFF_LCR, 8'h00);
    rc(`UDU_OFF_IER, 8'h07, "ier kept");
    wr(`UDU_OFF_IER, 8'h10);
    chk("sleep", 1'b1, o_sleeping);
    wr(`UDU_OFF_IER, 8'h00);
    chk("awake", 1'b0, o_sleeping);
    i_pll_bypass_test_n = 1'b0;
    tick(6);
    chk("bypass", 1'b1, o_pll_bypassed);
    i_pll_bypass_test_n = 1'b1;
    tick(6);
    chk("no bypass", 1'b0, o_pll_bypassed);
    $display("test registers done");
    // two characters per format, second one queued
    foreach (fmt[i]) begin
      wr(`UDU_OFF_LCR, fmt[i]);
      ev = 48'h0;
      np = 0;
      frame(8'h96, fmt[i]);
      frame(8'h3C, fmt[i]);
      fork
        udu_modem_i.sample(np, got);
        begin
          wr(`UDU_OFF_DATA, 8'h96);
          tick(20);
          wr(`UDU_OFF_DATA, 8'h3C);
        end
      join
      chk("tx frames", ev, got);
      tick(8);
    end
    wr(`UDU_OFF_IER, 8'h02);
    wr(`UDU_OFF_DATA, 8'h55);
    tick(40);
    rc(`UDU_OFF_ISR, 8'h02, "isr empty");
    rc(`UDU_OFF_ISR, 8'h01, "isr cleared");
    tick(200);
    $display("test transmit done");
    wr(`UDU_OFF_LCR, 8'h1B);
    wr(`UDU_OFF_IER, 8'h05);
    udu_modem_i.send({1'b1, 1'b0, 8'hC3, 1'b0}, 11);
    tick(4);
    rc(`UDU_OFF_ISR, 8'h04, "isr data");
    chk("irq", 1'b1, o_irq_pending);
    rc(`UDU_OFF_DATA, 8'hC3, "rx data");
    rc(`UDU_OFF_ISR, 8'h01, "isr none");
    udu_modem_i.send({1'b1, 1'b1, 8'hC3, 1'b0}, 11);
    tick(4);
    rc(`UDU_OFF_ISR, 8'h06, "isr status");
    rd(`UDU_OFF_LSR, v);
    chk("lsr parity", 8'h05, v & 8'h1F);
    rc(`UDU_OFF_ISR, 8'h04, "isr data");
    rc(`UDU_OFF_DATA, 8'hC3, "rx data");
    wr(`UDU_OFF_IER, 8'h00);
    udu_modem_i.send({1'b1, 1'b0, 8'hC3, 1'b0}, 11);
    tick(4);
    rc(`UDU_OFF_ISR, 8'h01, "isr masked");
    chk("irq masked", 1'b0, o_irq_pending);
    rc(`UDU_OFF_DATA, 8'hC3, "rx data");
    $display("test receive done");
    wr(`UDU_OFF_MCR, 8'h03);
    tick(2);
    chk("lines on", 2'h0, {o_request_to_send_out_n, o_terminal_ready_out_n});
    wr(`UDU_OFF_IER, 8'h08);
    udu_modem_i.set_lines(4'hE);
    tick(6);
    rc(`UDU_OFF_ISR, 8'h00, "isr modem");
    rd(`UDU_OFF_MSR, v);
    chk("msr cts", 8'h11, v & 8'h11);
    rc(`UDU_OFF_ISR, 8'h01, "isr none");
    wr(`UDU_OFF_MCR, 8'h13);
    tick(2);
    chk("loop lines", 2'h3, {o_request_to_send_out_n, o_terminal_ready_out_n});
    $display("test modem done");
    final_report;
  end
endmodule
bind udu_channel udu_chk udu_chk_i (.*);
`default_nettype wire
